/* hw/kps_sequencer.sv */
/*
 Key power sequencer top: key filter, supply sequencing, system enable, power latch
 with timeout, regulator-off select, secure engine off and new key reset pulse.
 Assumes analog comparator outputs arrive asynchronously and pass two flip-flops;
 software uses the plain register port on the same clock.
*/
// Decided for this implementation: strobed register access and the placing of the registers.
// Summary of operation
// - Filtered key high turns on main relay driver before the 5 V, 3.3 V and tracking supplies.
// - Key level must stay stable for the filter time before switching.
// - Relay battery: bias after battery UV clears, 5 V after regulator delay.
// - 3.3 V enabled one delay after 5 V rail exceeds its UV level.
// - Tracking sensor supplies enable together with the 5 V regulator.
// - Permanent battery: bias at key high, 5 V one delay after filter expiry.
// - Enable = ((hold active and timeout not expired) or key) and battery ok.
// - Key low and hold inactive switches system off after filter time.
// - Active hold keeps the system on until software writes hold bit to 1.
// - Unreleased hold forces shutdown after timeout chosen by 3-bit field.
// - Raw key level and filtered key level are readable.
// - With regulator-off select 0, all supply outputs switch off at the same instant.
// - Regulator-off select defaults 0; at 1 regulators outlive relay driver.
// - Select 1: relay off, regulators run until battery UV.
// - Key low disables injector and starter stages regardless of latch.
// - Starters shut off only after hold delay if condition still present.
// - Secure engine off touches only injector and starter stages.
// - Key falling edge starts internal timer; stages disabled after it.
// - Software still switches drivers during timer; config register enables function.
// - Battery overvoltage beyond its filter time switches the device off.
// - In latch, new key reset enabled and key rising pulses reset output.
`timescale 1ns/1ps
module kps_sequencer #(
   parameter int unsigned KEY_CYC = kps_pkg::KEY_FILTER_CYC,
   parameter int unsigned SEO_TIMER_CYC = kps_pkg::SEO_CYC,
   parameter int unsigned HOLD_CYC = kps_pkg::STARTER_HOLD_CYC,
   parameter int unsigned TIMEOUT_STEP_CYC = kps_pkg::LATCH_TIMEOUT_STEP_CYC,
   parameter int unsigned REG_CYC = kps_pkg::REG_DELAY_CYC,
   parameter int unsigned V33_CYC = kps_pkg::RAIL_3V3_DELAY_CYC,
   parameter int unsigned NK_CYC = kps_pkg::NEW_KEY_PULSE_CYC,
   parameter bit PERMANENT_BATTERY = 1'b0
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_key_level,
   input wire logic i_battery_not_undervoltage,
   input wire logic i_rail_5v_good,
   input wire logic i_battery_overvoltage_filtered,
   input wire logic [3:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   output kps_pkg::kps_supply_s o_supply,
   output kps_pkg::kps_drive_s o_drive,
   output logic o_system_enable,
   output logic o_new_key_reset_pulse
);
   logic key_s;
   logic bnu_s;
   logic r5_s;
   logic ov_s;
   logic key_flt_r;
   logic key_flt_d_r;
   logic [31:0] key_cnt_r;
   logic [7:0] ctrl_r;
   logic [7:0] cfg_r;
   logic [7:0] drv_r;
   logic [7:0] status_word;
   logic [31:0] to_cnt_r;
   logic [31:0] latch_limit;
   logic latch_timeout_not_expired;
   logic hold_active;
   logic en_nxt;
   logic [31:0] seq_cnt_r;
   logic [31:0] seo_cnt_r;
   logic seo_run_r;
   logic seo_fire_r;
   logic [31:0] hold_cnt_r;
   logic starter_off_r;
   logic [31:0] nk_cnt_r;
   logic key_rise;
   logic key_fall;
   kps_pkg::kps_supply_s sup_r;

   // Two-stage synchronisers
   kps_sync2 u_kps_sync2_key (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_key_level),
      .o_sync(key_s)
   );

   kps_sync2 u_kps_sync2_bnu (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_battery_not_undervoltage),
      .o_sync(bnu_s)
   );

   kps_sync2 u_kps_sync2_r5 (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_rail_5v_good),
      .o_sync(r5_s)
   );

   kps_sync2 u_kps_sync2_ov (
      .i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst),
      .i_async(i_battery_overvoltage_filtered),
      .o_sync(ov_s)
   );

   // Key deglitch filter
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         key_cnt_r <= 32'h0;
         key_flt_r <= 1'b0;
      end
      else if (key_s == key_flt_r)
         key_cnt_r <= 32'h0;
      else if (key_cnt_r >= KEY_CYC - 1)
      begin
         key_flt_r <= key_s;
         key_cnt_r <= 32'h0;
      end
      else
         key_cnt_r <= key_cnt_r + 32'h1;
   end

   // Edge detect on the filtered key
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         key_flt_d_r <= 1'b0;
      else
         key_flt_d_r <= key_flt_r;
   end
   assign key_rise = key_flt_r & ~key_flt_d_r;
   assign key_fall = ~key_flt_r & key_flt_d_r;

   // Register writes, one process per register
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         ctrl_r <= kps_pkg::CTRL_RESET;
      else if (i_wr && i_addr == kps_pkg::ADDR_CTRL)
         ctrl_r <= i_wdata;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         cfg_r <= kps_pkg::CFG_RESET;
      else if (i_wr && i_addr == kps_pkg::ADDR_CONFIG_SIX)
         cfg_r <= i_wdata;
   end

   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         drv_r <= kps_pkg::DRV_RESET;
      else if (i_wr && i_addr == kps_pkg::ADDR_DRIVER)
         drv_r <= i_wdata;
   end

   // Status word
   always_comb
   begin
      status_word = 8'h00;
      status_word[0] = key_s;
      status_word[1] = key_flt_r;
      status_word[2] = o_system_enable;
      status_word[3] = seo_run_r;
      status_word[4] = ~latch_timeout_not_expired;
   end

   // Register reads, data one cycle later
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         o_rdata <= 8'h00;
      else if (i_rd)
      begin
         unique case (i_addr)
            kps_pkg::ADDR_CTRL: o_rdata <= ctrl_r;
            kps_pkg::ADDR_CONFIG_SIX: o_rdata <= cfg_r;
            kps_pkg::ADDR_STATUS: o_rdata <= status_word;
            kps_pkg::ADDR_DRIVER: o_rdata <= drv_r;
            default: o_rdata <= 8'h00;
         endcase
      end
      else
         o_rdata <= 8'h00;
   end

   // Power latch timeout
   assign hold_active = ~ctrl_r[kps_pkg::CTRL_HOLD_N_BIT];
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || !hold_active || key_flt_r)
         to_cnt_r <= 32'h0;
      else if (to_cnt_r != 32'hffffffff)
         to_cnt_r <= to_cnt_r + 32'h1;
   end
   // Field 0 disables the timeout; otherwise length is field times step
   assign latch_limit = 32'(ctrl_r[kps_pkg::CTRL_TIMEOUT_LSB +: 3]) * TIMEOUT_STEP_CYC;
   assign latch_timeout_not_expired =
      (ctrl_r[kps_pkg::CTRL_TIMEOUT_LSB +: 3] == 3'h0) || (to_cnt_r < latch_limit);

   // System enable equation
   assign en_nxt = ((hold_active & latch_timeout_not_expired) | key_flt_r) & bnu_s & ~ov_s;
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         o_system_enable <= 1'b0;
      else
         o_system_enable <= en_nxt;
   end

   // Supply sequencing
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         sup_r <= '0;
         seq_cnt_r <= 32'h0;
      end
      else if (!o_system_enable)
      begin
         sup_r.main_relay_driver <= 1'b0;
         seq_cnt_r <= 32'h0;
         if (!ctrl_r[kps_pkg::CTRL_REG_OFF_SEL_BIT] || !bnu_s)
         begin
            sup_r <= '0;
         end
         if (PERMANENT_BATTERY && key_s && !ctrl_r[kps_pkg::CTRL_REG_OFF_SEL_BIT])
            sup_r.bias_en <= 1'b1;
      end
      else
      begin
         sup_r.main_relay_driver <= 1'b1;
         if (PERMANENT_BATTERY || bnu_s)
            sup_r.bias_en <= 1'b1;
         if (sup_r.bias_en && !sup_r.rail_5v_en)
         begin
            if (seq_cnt_r >= REG_CYC - 1)
            begin
               sup_r.rail_5v_en <= 1'b1;
               sup_r.tracking_sensor_supply_a <= 1'b1;
               sup_r.tracking_sensor_supply_b <= 1'b1;
               seq_cnt_r <= 32'h0;
            end
            else
               seq_cnt_r <= seq_cnt_r + 32'h1;
         end
         else if (sup_r.rail_5v_en && !sup_r.rail_3v3_en && r5_s)
         begin
            if (seq_cnt_r >= V33_CYC - 1)
               sup_r.rail_3v3_en <= 1'b1;
            else
               seq_cnt_r <= seq_cnt_r + 32'h1;
         end
      end
   end
   assign o_supply = sup_r;

   // Secure engine off timer from key fall
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || key_flt_r || !cfg_r[kps_pkg::CFG_SEO_EN_BIT])
      begin
         seo_cnt_r <= 32'h0;
         seo_run_r <= 1'b0;
         seo_fire_r <= 1'b0;
      end
      else if (key_fall)
         seo_run_r <= 1'b1;
      else if (seo_run_r)
      begin
         if (seo_cnt_r >= SEO_TIMER_CYC - 1)
         begin
            seo_fire_r <= 1'b1;
            seo_run_r <= 1'b0;
         end
         else
            seo_cnt_r <= seo_cnt_r + 32'h1;
      end
   end

   // Starter hold delay after the timer expires
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || !seo_fire_r)
         hold_cnt_r <= 32'h0;
      else if (hold_cnt_r < HOLD_CYC - 1)
         hold_cnt_r <= hold_cnt_r + 32'h1;
   end

   // Starter shut-off flag
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || !seo_fire_r)
         starter_off_r <= 1'b0;
      else if (hold_cnt_r >= HOLD_CYC - 1)
         starter_off_r <= 1'b1;
   end

   // Driver gating: only injectors and starters
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
         o_drive <= '0;
      else
      begin
         o_drive.injector_stages <= drv_r[3:0] & {4{~seo_fire_r}};
         o_drive.starter_relay_driver_a <= drv_r[4] & ~starter_off_r;
         o_drive.starter_relay_driver_b <= drv_r[5] & ~starter_off_r;
      end
   end

   // New key reset pulse
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         nk_cnt_r <= 32'h0;
         o_new_key_reset_pulse <= 1'b0;
      end
      else if (key_rise && hold_active && o_system_enable &&
               ctrl_r[kps_pkg::CTRL_NEW_KEY_EN_BIT])
      begin
         nk_cnt_r <= 32'h0;
         o_new_key_reset_pulse <= 1'b1;
      end
      else if (o_new_key_reset_pulse)
      begin
         if (nk_cnt_r >= NK_CYC - 1)
            o_new_key_reset_pulse <= 1'b0;
         else
            nk_cnt_r <= nk_cnt_r + 32'h1;
      end
   end
endmodule

module kps_sync2 #(
   parameter bit RESET_LEVEL = 1'b0
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_async,
   output logic o_sync
);
   logic meta_r;

   // First stage is read only by the second
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst)
      begin
         meta_r <= RESET_LEVEL;
         o_sync <= RESET_LEVEL;
      end
      else
      begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule

/* hw/kps_pkg.sv */
/*
 Package for the key power sequencer: register map, field positions, reset values,
 timing constants and packed carrier structs.
 Assumes a 250 MHz reference clock; counts derive from nominal times.
*/
package kps_pkg;
   localparam int unsigned CLK_KHZ = 250000;
   // Key filter time (ms), nominal
   localparam int unsigned KEY_FILTER_TIME_MS = 16;
   localparam int unsigned KEY_FILTER_CYC = KEY_FILTER_TIME_MS * CLK_KHZ;
   // Regulator delay after bias (us), plain default
   localparam int unsigned REG_DELAY_US = 100;
   localparam int unsigned REG_DELAY_CYC = REG_DELAY_US * (CLK_KHZ / 1000);
   // Delay from 5 V good to 3.3 V enable (us)
   localparam int unsigned RAIL_3V3_DELAY_US = 1000;
   localparam int unsigned RAIL_3V3_DELAY_CYC = RAIL_3V3_DELAY_US * (CLK_KHZ / 1000);
   // Secure engine off timer (ms), typical
   localparam int unsigned SEO_TIME_MS = 225;
   localparam int unsigned SEO_CYC = SEO_TIME_MS * CLK_KHZ;
   // Starter hold delay (ms), plain default
   localparam int unsigned STARTER_HOLD_MS = 10;
   localparam int unsigned STARTER_HOLD_CYC = STARTER_HOLD_MS * CLK_KHZ;
   // New key reset pulse (us), plain default
   localparam int unsigned NEW_KEY_PULSE_US = 1000;
   localparam int unsigned NEW_KEY_PULSE_CYC = NEW_KEY_PULSE_US * (CLK_KHZ / 1000);
   // Latch timeout unit (ms) per config step, plain default
   localparam int unsigned LATCH_TIMEOUT_STEP_MS = 100;
   localparam int unsigned LATCH_TIMEOUT_STEP_CYC = LATCH_TIMEOUT_STEP_MS * CLK_KHZ;

   // Register offsets
   localparam logic [3:0] ADDR_CTRL = 4'h0;
   localparam logic [3:0] ADDR_CONFIG_SIX = 4'h4;
   localparam logic [3:0] ADDR_STATUS = 4'h8;
   localparam logic [3:0] ADDR_DRIVER = 4'hc;

   // Control register fields
   localparam int unsigned CTRL_HOLD_N_BIT = 0;
   localparam int unsigned CTRL_REG_OFF_SEL_BIT = 1;
   localparam int unsigned CTRL_NEW_KEY_EN_BIT = 2;
   localparam int unsigned CTRL_TIMEOUT_LSB = 4;
   localparam logic [7:0] CTRL_RESET = 8'h01;
   // Config six fields
   localparam int unsigned CFG_SEO_EN_BIT = 0;
   localparam logic [7:0] CFG_RESET = 8'h01;
   // Driver register fields: injectors [3:0], starters [5:4]
   localparam logic [7:0] DRV_RESET = 8'h00;

   typedef struct packed {
      logic main_relay_driver;
      logic bias_en;
      logic rail_5v_en;
      logic rail_3v3_en;
      logic tracking_sensor_supply_a;
      logic tracking_sensor_supply_b;
   } kps_supply_s;

   typedef struct packed {
      logic [3:0] injector_stages;
      logic starter_relay_driver_a;
      logic starter_relay_driver_b;
   } kps_drive_s;
endpackage

/* test/kps_sequencer_properties.sv */
/*
 Checker for the key power sequencer top ports.
 Assumes one clock domain and the shortened counts of the bench.
*/
`timescale 1ns/1ps
module kps_sequencer_properties #(
   parameter int unsigned KEY_CYC = 8,
   parameter int unsigned SEO_TIMER_CYC = 20,
   parameter int unsigned HOLD_CYC = 5,
   parameter int unsigned NK_CYC = 4
) (
   input wire logic i_ref_clk,
   input wire logic i_sys_rst,
   input wire logic i_key_level,
   input wire logic i_battery_not_undervoltage,
   input wire logic i_rail_5v_good,
   input wire logic i_battery_overvoltage_filtered,
   input wire kps_pkg::kps_supply_s o_supply,
   input wire kps_pkg::kps_drive_s o_drive,
   input wire logic o_system_enable,
   input wire logic o_new_key_reset_pulse
);
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_sys_rst);
   int key_low_cnt;
   int nk_cnt;
   // Counts raw key low time and reset pulse width
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || i_key_level)
         key_low_cnt <= 0;
      else if (key_low_cnt < 255)
         key_low_cnt <= key_low_cnt + 1;
   end
   always_ff @(posedge i_ref_clk)
   begin
      if (i_sys_rst || !o_new_key_reset_pulse)
         nk_cnt <= 0;
      else
         nk_cnt <= nk_cnt + 1;
   end
   sequence s_batt_lost;
      !i_battery_not_undervoltage [*5];
   endsequence
   sequence s_overvolt;
      i_battery_overvoltage_filtered [*5];
   endsequence
   AST_RELAY_FIRST: assert property ($rose(o_supply.rail_5v_en) |->
      o_supply.main_relay_driver && o_supply.bias_en) else $error("5 V on before relay");
   AST_TRK_WITH_5V: assert property (o_supply.tracking_sensor_supply_a == o_supply.rail_5v_en
      && o_supply.tracking_sensor_supply_b == o_supply.rail_5v_en) else $error("trk mismatch");
   AST_3V3_AFTER_GOOD: assert property ($rose(o_supply.rail_3v3_en) |->
      $past(i_rail_5v_good, 4)) else $error("3.3 V too early");
   AST_OFF_TOGETHER: assert property ($fell(o_supply.rail_5v_en) |->
      !o_supply.rail_3v3_en) else $error("supplies not off together");
   AST_BATT_OFF: assert property (s_batt_lost |-> !o_system_enable)
      else $error("enable kept on low battery");
   AST_OVERVOLT_OFF: assert property (s_overvolt |-> !o_system_enable)
      else $error("enable kept on overvoltage");
   AST_RELAY_OFF: assert property (!o_system_enable [*2] |-> !o_supply.main_relay_driver)
      else $error("relay on while disabled");
   AST_NK_WIDTH: assert property ($fell(o_new_key_reset_pulse) |-> nk_cnt == NK_CYC)
      else $error("reset pulse width wrong");
   AST_SEO_INJ: assert property (key_low_cnt > KEY_CYC + SEO_TIMER_CYC + 8 |->
      o_drive.injector_stages == 4'h0) else $error("injectors on after timer");
   AST_SEO_START: assert property (key_low_cnt > KEY_CYC + SEO_TIMER_CYC + HOLD_CYC + 8 |->
      !o_drive.starter_relay_driver_a && !o_drive.starter_relay_driver_b)
      else $error("starters on after hold");
endmodule

bind kps_sequencer kps_sequencer_properties #(.KEY_CYC(KEY_CYC), .SEO_TIMER_CYC(SEO_TIMER_CYC),
   .HOLD_CYC(HOLD_CYC), .NK_CYC(NK_CYC)) u_kps_sequencer_properties (.i_ref_clk(i_ref_clk),
   .i_sys_rst(i_sys_rst), .i_key_level(i_key_level),
   .i_battery_not_undervoltage(i_battery_not_undervoltage), .i_rail_5v_good(i_rail_5v_good),
   .i_battery_overvoltage_filtered(i_battery_overvoltage_filtered), .o_supply(o_supply),
   .o_drive(o_drive), .o_system_enable(o_system_enable),
   .o_new_key_reset_pulse(o_new_key_reset_pulse));

/* test/kps_far_model.sv */
/*
 Far side model: 5 V regulator reporting good three cycles after enable.
 Assumes the same clock as the sequencer.
*/
`timescale 1ns/1ps
module kps_far_model (
   input wire logic i_ref_clk,
   input wire logic i_rail_5v_en,
   output logic o_rail_5v_good
);
   logic [2:0] ramp_r;
   // Rail rises slowly and drops at once
   always_ff @(posedge i_ref_clk)
   begin
      ramp_r <= i_rail_5v_en ? {ramp_r[1:0], 1'b1} : 3'h0;
   end
   assign o_rail_5v_good = ramp_r[2];
endmodule

/* test/kps_sequencer_tb.sv */
/*
 Self-checking bench for the key power sequencer.
 Assumes shortened counts and the far side model for the 5 V good level.
*/
`timescale 1ns/1ps
module kps_sequencer_tb;
   localparam int KC = 8, SC = 20, HC = 5, TC = 10, RC = 4, VC = 4;
   logic i_ref_clk = 1'b0, i_sys_rst = 1'b1, key = 1'b0, batt = 1'b1, ov = 1'b0;
   logic good, wr = 1'b0, rd = 1'b0, nk;
   logic [3:0] addr = 4'h0;
   logic [7:0] wdata = 8'h00, rdata;
   kps_pkg::kps_supply_s sup;
   kps_pkg::kps_drive_s drv;
   logic en;
   int bad_count = 0, checks_done = 0, n;
   logic [11:0] rows [5] = '{{kps_pkg::ADDR_CTRL, 8'h01}, {kps_pkg::ADDR_CONFIG_SIX, 8'h01},
      {kps_pkg::ADDR_DRIVER, 8'h00}, {kps_pkg::ADDR_STATUS, 8'h00}, {4'h2, 8'h00}};
   always #2 i_ref_clk = ~i_ref_clk;
   kps_sequencer #(.KEY_CYC(KC), .SEO_TIMER_CYC(SC), .HOLD_CYC(HC), .TIMEOUT_STEP_CYC(TC),
      .REG_CYC(RC), .V33_CYC(VC), .NK_CYC(4)) u_kps_sequencer (.i_ref_clk(i_ref_clk),
      .i_sys_rst(i_sys_rst), .i_key_level(key), .i_battery_not_undervoltage(batt),
      .i_rail_5v_good(good), .i_battery_overvoltage_filtered(ov), .i_addr(addr),
      .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .o_supply(sup),
      .o_drive(drv), .o_system_enable(en), .o_new_key_reset_pulse(nk));
   kps_far_model u_kps_far_model (.i_ref_clk(i_ref_clk), .i_rail_5v_en(sup.rail_5v_en),
      .o_rail_5v_good(good));
   task automatic results();
      $display("checks %0d mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic ck(input logic [7:0] g, input logic [7:0] e);
      checks_done++;
      if (g !== e)
      begin
         bad_count++;
         $display("[FAIL] %0t got %h want %h", $time, g, e);
      end
   endtask
   function automatic logic pick(input int s);
      case (s)
         0: return sup.main_relay_driver;
         1: return sup.rail_5v_en;
         2: return sup.rail_3v3_en;
         3: return nk;
         4: return drv.injector_stages === 4'h0;
         5: return !drv.starter_relay_driver_a && !drv.starter_relay_driver_b;
         6: return !en;
         7: return !sup.main_relay_driver;
         default: return !sup.rail_5v_en;
      endcase
   endfunction
   task automatic wt(input int s);
      n = 0;
      while (pick(s) !== 1'b1)
      begin
         @(posedge i_ref_clk);
         #1;
         n++;
         if (n > 300)
         begin
            bad_count++;
            $display("[FAIL] %0t wait %0d timed out", $time, s);
            results();
         end
      end
   endtask
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge i_ref_clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a, input logic [7:0] e);
      @(posedge i_ref_clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge i_ref_clk);
      rd <= 1'b0;
      #1;
      ck(rdata, e);
   endtask
   task automatic setkey(input logic v);
      @(posedge i_ref_clk);
      key <= v;
      #1;
   endtask
   initial
   begin
      repeat (3) @(posedge i_ref_clk);
      i_sys_rst <= 1'b0;
      for (int i = 0; i < 5; i++)
         rreg(rows[i][11:8], rows[i][7:0]);
      $display("register defaults done");
      setkey(1'b1);
      wt(0);
      ck(8'(sup.rail_5v_en), 8'h00);
      ck(8'(n >= KC), 8'h01);
      wt(1);
      ck(8'(n >= RC), 8'h01);
      wt(2);
      ck(8'(n >= VC), 8'h01);
      rreg(kps_pkg::ADDR_STATUS, 8'h07);
      setkey(1'b0);
      repeat (3) @(posedge i_ref_clk);
      setkey(1'b1);
      repeat (12) @(posedge i_ref_clk);
      #1;
      ck(8'(en), 8'h01);
      $display("power up done");
      wreg(kps_pkg::ADDR_CTRL, 8'h00);
      wreg(kps_pkg::ADDR_DRIVER, 8'h3f);
      repeat (2) @(posedge i_ref_clk);
      #1;
      ck(8'(drv), 8'h3f);
      setkey(1'b0);
      wt(4);
      ck(8'(n >= SC), 8'h01);
      ck(8'(drv.starter_relay_driver_a), 8'h01);
      ck(8'({en, sup}), 8'h7f);
      wt(5);
      ck(8'(n >= HC - 1), 8'h01);
      $display("secure engine off done");
      wreg(kps_pkg::ADDR_CTRL, 8'h04);
      setkey(1'b1);
      wt(3);
      ck(8'(en), 8'h01);
      repeat (12) @(posedge i_ref_clk);
      wreg(kps_pkg::ADDR_CTRL, 8'h10);
      setkey(1'b0);
      wt(6);
      ck(8'(n >= KC + TC), 8'h01);
      repeat (2) @(posedge i_ref_clk);
      #1;
      ck(8'(sup), 8'h00);
      $display("latch timeout done");
      wreg(kps_pkg::ADDR_CTRL, 8'h03);
      setkey(1'b1);
      wt(1);
      setkey(1'b0);
      wt(7);
      ck(8'(sup.rail_5v_en), 8'h01);
      wreg(kps_pkg::ADDR_CTRL, 8'h01);
      wt(8);
      ck(8'(sup.rail_3v3_en), 8'h00);
      $display("regulator off select done");
      setkey(1'b1);
      wt(0);
      @(posedge i_ref_clk);
      batt <= 1'b0;
      wt(6);
      @(posedge i_ref_clk);
      batt <= 1'b1;
      wt(0);
      @(posedge i_ref_clk);
      ov <= 1'b1;
      wt(6);
      ck(8'(en), 8'h00);
      $display("battery faults done");
      results();
   end
endmodule
